// File: logic/set_sleep_exec.sv
// Purpose: Executes the set-all-ones and sleep instructions of an 8-bit core.
// Assumes: instr_word is held stable by fetch for a whole four-phase cycle.
// Notes:   Other opcodes are ignored; wake events come from outside logic.
// Function
// - Set-all-ones writes FFh to addressed byte.
// - Bank bit chooses access bank or bank register.
// - Extended set indexes addresses up to 5Fh.
// - Sleep clears the power-down flag.
// - Sleep sets the time-out flag.
// - Sleep clears watchdog count and postscaler.
// - Sleep halts oscillator until wake-up.
// - Watchdog wake-up clears the time-out flag.
`timescale 1ns/1ps
`default_nettype none
module set_sleep_exec (
    input  wire logic        ref_clk,         // Core clock, 100 MHz.
    input  wire logic        rst,             // Asynchronous reset, active high.
    input  wire logic [15:0] instr_word,      // Fetched program word.
    input  wire logic        instr_valid,     // Word is valid this cycle.
    input  wire logic [3:0]  bank_select_reg, // Current bank select value.
    input  wire logic [11:0] index_base,      // Index pointer for literal offset.
    input  wire logic        ext_set_en,      // Extended instruction set enabled.
    input  wire logic        wake_event,      // Wake-up request, from a pin.
    input  wire logic        wake_by_watchdog, // Wake caused by watchdog, from a pin.
    output logic             mem_we,          // Data-memory write strobe.
    output logic [11:0]      mem_addr,        // Data-memory byte address.
    output logic [7:0]       mem_wdata,       // Data-memory write data.
    output logic             power_down_flag, // Power-down status, low after sleep.
    output logic             timeout_flag,    // Time-out status.
    output logic             watchdog_clear,  // Clears watchdog_counter and postscaler.
    output logic             osc_run,         // Oscillator enable.
    output logic [1:0]       phase            // Current phase of the instruction cycle.
);
    logic                        wake_meta;
    logic                        wake_sync;
    logic                        watchdog_meta;
    logic                        watchdog_sync;
    logic                        next_wake_meta;
    logic                        next_wake_sync;
    logic                        next_watchdog_meta;
    logic                        next_watchdog_sync;
    set_sleep_pkg::run_type      state;
    set_sleep_pkg::run_type      next_state;
    logic [1:0]                  next_phase;
    logic                        next_osc_run;
    logic                        next_mem_we;
    logic [11:0]                 next_mem_addr;
    logic [7:0]                  next_mem_wdata;
    logic                        next_power_down_flag;
    logic                        next_timeout_flag;
    logic                        next_watchdog_clear;
    logic                        is_set;
    logic                        is_sleep;
    logic                        set_fires;
    logic                        sleep_fires;
    logic                        wake_fires;
    logic [7:0]                  file_addr;
    logic [11:0]                 set_addr;

    // Both wake inputs come from pins, so each passes two flip-flops first.
    always_comb
    begin
        next_wake_meta     = wake_event;
        next_wake_sync     = wake_meta;
        next_watchdog_meta = wake_by_watchdog;
        next_watchdog_sync = watchdog_meta;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wake_meta     <= 1'b0;
            wake_sync     <= 1'b0;
            watchdog_meta <= 1'b0;
            watchdog_sync <= 1'b0;
        end
        else
        begin
            wake_meta     <= next_wake_meta;
            wake_sync     <= next_wake_sync;
            watchdog_meta <= next_watchdog_meta;
            watchdog_sync <= next_watchdog_sync;
        end
    end

    assign file_addr   = instr_word[7:0];
    assign is_set      = instr_valid
                         && instr_word[15:set_sleep_pkg::SET_OP_POS] == set_sleep_pkg::SET_OP_HI;
    assign is_sleep    = instr_valid && instr_word == set_sleep_pkg::SLEEP_WORD;
    assign set_fires   = state == set_sleep_pkg::RUN_STATE && is_set
                         && phase == (set_sleep_pkg::PHASE_WRITE - 2'h1);
    assign sleep_fires = state == set_sleep_pkg::RUN_STATE && is_sleep
                         && phase == set_sleep_pkg::PHASE_LAST;
    assign wake_fires  = state == set_sleep_pkg::SLEEP_STATE && wake_sync;

    // Operand address; the indexed mode applies only with the bank bit clear.
    always_comb
    begin
        if (instr_word[set_sleep_pkg::BANK_BIT_POS])
            set_addr = {bank_select_reg, file_addr};
        else if (ext_set_en && file_addr <= set_sleep_pkg::INDEXED_LIMIT)
            set_addr = index_base + {4'h0, file_addr};
        else if (file_addr < set_sleep_pkg::ACCESS_SPLIT)
            set_addr = {4'h0, file_addr};
        else
            set_addr = {set_sleep_pkg::ACCESS_HIGH_BANK, file_addr};
    end

    always_comb
    begin
        next_state   = state;
        next_phase   = phase;
        next_osc_run = osc_run;
        case (state)
            set_sleep_pkg::RUN_STATE:
            begin
                // Each instruction takes exactly four phases, then the next word.
                next_phase = phase + 2'h1;
                if (sleep_fires)
                begin
                    next_osc_run = 1'b0;
                    next_state   = set_sleep_pkg::SLEEP_STATE;
                end
            end
            set_sleep_pkg::SLEEP_STATE:
            begin
                // Phase is parked at zero so a woken core starts a fresh cycle.
                next_phase = 2'h0;
                if (wake_fires)
                begin
                    next_osc_run = 1'b1;
                    next_state   = set_sleep_pkg::RUN_STATE;
                end
            end
            default:
            begin
                next_state   = set_sleep_pkg::RUN_STATE;
                next_phase   = 2'h0;
                next_osc_run = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state   <= set_sleep_pkg::RUN_STATE;
            phase   <= 2'h0;
            osc_run <= 1'b1;
        end
        else
        begin
            state   <= next_state;
            phase   <= next_phase;
            osc_run <= next_osc_run;
        end
    end

    always_comb
    begin
        next_mem_we    = 1'b0;
        next_mem_addr  = mem_addr;
        next_mem_wdata = mem_wdata;
        if (set_fires)
        begin
            next_mem_we    = 1'b1;
            next_mem_addr  = set_addr;
            next_mem_wdata = set_sleep_pkg::ALL_ONES;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            mem_we    <= 1'b0;
            mem_addr  <= 12'h000;
            mem_wdata <= 8'h00;
        end
        else
        begin
            mem_we    <= next_mem_we;
            mem_addr  <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
        end
    end

    // Set-all-ones touches none of these flags; only sleep and wake do.
    always_comb
    begin
        next_power_down_flag = power_down_flag;
        next_timeout_flag    = timeout_flag;
        next_watchdog_clear  = 1'b0;
        if (sleep_fires)
        begin
            next_power_down_flag = 1'b0;
            next_timeout_flag    = 1'b1;
            next_watchdog_clear  = 1'b1;
        end
        else if (wake_fires && watchdog_sync)
        begin
            next_timeout_flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            power_down_flag <= 1'b1;
            timeout_flag    <= 1'b1;
            watchdog_clear  <= 1'b0;
        end
        else
        begin
            power_down_flag <= next_power_down_flag;
            timeout_flag    <= next_timeout_flag;
            watchdog_clear  <= next_watchdog_clear;
        end
    end
endmodule : set_sleep_exec
`default_nettype wire

// File: logic/set_sleep_pkg.sv
// Purpose: Constants for the set-all-ones and sleep execution block.
// Assumes: 16-bit program words, 8-bit data bytes, 12-bit data addresses.
// Notes:   Timing is counted in core clock phases, four per instruction cycle.
package set_sleep_pkg;
    localparam int          WORD_W           = 16;
    localparam int          DATA_W           = 8;
    localparam int          ADDR_W           = 12;
    localparam logic [6:0]  SET_OP_HI        = 7'h34;
    localparam int          SET_OP_POS       = 9;
    localparam int          BANK_BIT_POS     = 8;
    localparam logic [15:0] SLEEP_WORD       = 16'h0003;
    localparam logic [7:0]  ALL_ONES         = 8'hff;
    localparam logic [7:0]  INDEXED_LIMIT    = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
    localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hf;
    localparam int          PHASES           = 4;
    localparam logic [1:0]  PHASE_LAST       = 2'h3;
    localparam logic [1:0]  PHASE_WRITE      = 2'h3;

    typedef enum logic [1:0] {
        RUN_STATE   = 2'b00,
        SLEEP_STATE = 2'b01
    } run_type;
endpackage : set_sleep_pkg

// File: bench/set_sleep_exec_properties.sv
// Purpose: Port checks for set_sleep_exec.
// Assumes: Words held for all four phases.
// Notes:   Bound after the module.
`timescale 1ns/1ps
`default_nettype none
module set_sleep_props (
    input wire logic        ref_clk, // In.
    input wire logic        rst, // In.
    input wire logic [15:0] instr_word, // In.
    input wire logic        instr_valid, // In.
    input wire logic [3:0]  bank_select_reg, // In.
    input wire logic [11:0] index_base, // In.
    input wire logic        ext_set_en, // In.
    input wire logic        mem_we, // Out.
    input wire logic [11:0] mem_addr, // Out.
    input wire logic [7:0]  mem_wdata, // Out.
    input wire logic        power_down_flag, // Out.
    input wire logic        timeout_flag, // Out.
    input wire logic        watchdog_clear, // Out.
    input wire logic        osc_run, // Out.
    input wire logic [1:0]  phase // Out.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic [7:0] offs = instr_word[7:0];
    wire logic       idx = ext_set_en && offs <= 8'h5f;
    write_ones_a: assert property (mem_we |-> mem_wdata == 8'hff && phase == 2'h3)
        else $error("bad write");
    we_pulse_a: assert property (mem_we |=> !mem_we) else $error("long write");
    bank_addr_a: assert property (mem_we && instr_word[8] |-> mem_addr == {bank_select_reg, offs})
        else $error("bank addr");
    access_addr_a: assert property (mem_we && !instr_word[8] && !idx
        |-> mem_addr == {offs < 8'h60 ? 4'h0 : 4'hf, offs}) else $error("access addr");
    index_addr_a: assert property (mem_we && !instr_word[8] && idx
        |-> mem_addr == index_base + {4'h0, offs}) else $error("index addr");
    sleep_entry_a: assert property (instr_valid && instr_word == 16'h0003 && phase == 2'h3
        |=> !power_down_flag && timeout_flag && watchdog_clear && !osc_run) else $error("no sleep");
    clear_pulse_a: assert property (watchdog_clear |=> !watchdog_clear)
        else $error("long clear");
    asleep_idle_a: assert property (!osc_run |-> phase == 2'h0 && !mem_we) else $error("awake");
endmodule : set_sleep_props
bind set_sleep_exec set_sleep_props i_set_sleep_props (.*);
`default_nettype wire

// File: bench/test_set_sleep_exec.sv
// Purpose: Self-checking bench for set_sleep_exec.
// Assumes: Words start at the edge that ends phase 3.
// Notes:   Wake-ups are driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module test_set_sleep_exec;
    logic        ref_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
    logic        wake_event = 1'b0, wake_by_watchdog = 1'b0, mem_we, power_down_flag;
    logic        timeout_flag, watchdog_clear, osc_run;
    logic [15:0] instr_word = 16'h0000;
    logic [11:0] index_base = 12'h123, mem_addr;
    logic [3:0]  bank_select_reg = 4'h5;
    logic [7:0]  mem_wdata;
    logic [1:0]  phase;
    int          error_cnt = 0, checked = 0;
    set_sleep_exec i_set_sleep_exec (.*);
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic [15:0] w, input logic [11:0] a, input logic we);
        instr_word <= w;
        instr_valid <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk(we ? {mem_we, mem_addr, mem_wdata} : mem_we, we ? {we, a, 8'hff} : we);
        @(posedge ref_clk);
        $display("test %h done", w);
    endtask : run
    task automatic nap(input logic wdt);
        run(16'h0003, 12'h000, 1'b0);
        instr_valid <= 1'b0;
        wake_event <= 1'b1;
        wake_by_watchdog <= wdt;
        #1 chk({power_down_flag, timeout_flag, watchdog_clear, osc_run}, 4'h6);
        repeat (4) @(posedge ref_clk);
        wake_event <= 1'b0;
        #1 chk({osc_run, timeout_flag}, {1'b1, !wdt});
        do @(posedge ref_clk); while (phase !== 2'h3);
    endtask : nap
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (8) @(posedge ref_clk);
        chk({power_down_flag, timeout_flag, osc_run}, 3'h7);
        rst <= 1'b0;
        do @(posedge ref_clk); while (phase !== 2'h3);
        run(16'h699a, 12'h59a, 1'b1);
        run(16'h685f, 12'h05f, 1'b1);
        run(16'h6860, 12'hf60, 1'b1);
        run(16'h6a00, 12'h000, 1'b0);
        ext_set_en <= 1'b1;
        run(16'h685f, 12'h182, 1'b1);
        run(16'h6860, 12'hf60, 1'b1);
        nap(1'b0);
        nap(1'b1);
        run(16'h6900, 12'h500, 1'b1);
        report_and_stop();
    end
    initial
    begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
endmodule : test_set_sleep_exec
`default_nettype wire
